// ==== bitu_pkg.sv ====
// Package for the bit interval timer serial controller: device map, own registers, types.
package bitu_pkg;

  // ****************************************************************
  // Device register map and control bit masks
  // ****************************************************************
  localparam logic [7:0] BITU_ADDR_CONTROL = 8'h42;
  localparam logic [7:0] BITU_ADDR_RELOAD  = 8'h43;
  localparam logic [7:0] BITU_ADDR_COUNT   = 8'h44;
  localparam logic [7:0] BITU_M_RX_LEVEL   = 8'h01;
  localparam logic [7:0] BITU_M_TX_BIT     = 8'h02;
  localparam logic [7:0] BITU_M_EDGE_ARM   = 8'h04;
  localparam logic [7:0] BITU_M_RUN        = 8'h08;
  localparam logic [7:0] BITU_M_TX_ROUTE   = 8'h10;
  localparam logic [7:0] BITU_M_IRQ_CARRY  = 8'h20;
  localparam logic [7:0] BITU_M_CLK_MAIN   = 8'h40;
  localparam logic [7:0] BITU_M_CLK_AUX    = 8'h80;
  localparam logic [7:0] BITU_BYTE_ZERO    = 8'h00;

  // ****************************************************************
  // Controller registers seen by software
  // ****************************************************************
  localparam logic [3:0] BITU_REG_COMMAND  = 4'h0;
  localparam logic [3:0] BITU_REG_STATUS   = 4'h1;
  localparam logic [3:0] BITU_REG_TX_DATA  = 4'h2;
  localparam logic [3:0] BITU_REG_RX_DATA  = 4'h3;
  localparam logic [3:0] BITU_REG_FULL_BIT = 4'h4;
  localparam logic [3:0] BITU_REG_HALF_BIT = 4'h5;
  localparam int         BITU_CMD_TX       = 0;
  localparam int         BITU_CMD_RX       = 1;
  localparam int         BITU_CMD_PARITY   = 2;
  localparam int         BITU_CMD_AUX_CLK  = 3;
  localparam int         BITU_ST_DONE      = 1;

  // ****************************************************************
  // Frame and sequencing counts
  // ****************************************************************
  localparam logic [3:0] BITU_TX_BITS_PAR  = 4'hC;
  localparam logic [3:0] BITU_TX_BITS_NOP  = 4'hB;
  localparam logic [3:0] BITU_RX_BITS_PAR  = 4'hB;
  localparam logic [3:0] BITU_RX_BITS_NOP  = 4'hA;
  localparam logic [3:0] BITU_ONE          = 4'h1;
  localparam logic [2:0] BITU_INIT_LAST    = 3'h4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       wr;
    logic       rd;
  } bitu_bus_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bitu_cmd_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_INIT,
    S_WAIT_IRQ,
    S_RD_GAP,
    S_RD_TAKE
  } bitu_state_t;

endpackage

// ==== bitu_ctrl.sv ====
// Controller that runs a half-duplex serial frame through the bit interval timer registers.
`timescale 1ns/100ps

module bitu_ctrl
  import bitu_pkg::*;
(
  input  wire logic       CLOCK_IN,
  input  wire logic       RST_IN,
  input  wire bitu_cmd_t  CMD_IN,
  output logic [7:0]      CMD_RDATA_OUT,
  output bitu_bus_t       DEV_BUS_OUT,
  input  wire logic [7:0] DEV_RDATA_IN,
  input  wire logic       DEV_IRQ_IN,
  output logic            EDGE_FALL_SELECT_OUT,
  output logic            RECEIVE_PIN_IRQ_ENABLE_OUT
);

  // ****************************************************************
  // State
  // ****************************************************************
  bitu_state_t state_q,     state_d;
  logic [2:0]  step_q,      step_d;
  logic [3:0]  bitcnt_q,    bitcnt_d;
  logic [11:0] frame_q,     frame_d;
  logic [7:0]  ctl_base_q,  ctl_base_d;
  logic        tx_mode_q,   tx_mode_d;
  logic        parity_q,    parity_d;
  logic [7:0]  tx_data_q,   tx_data_d;
  logic [7:0]  rx_data_q,   rx_data_d;
  logic [7:0]  full_q,      full_d;
  logic [7:0]  half_q,      half_d;
  logic        done_q,      done_d;
  logic        perr_q,      perr_d;
  logic        ferr_q,      ferr_d;
  logic        edge_sel_q,  edge_sel_d;
  logic        irq_en_q,    irq_en_d;
  logic        irq_prev_q;
  logic        aux_clk_q,   aux_clk_d;
  bitu_bus_t   bus_q,       bus_d;
  logic [7:0]  rdata_q,     rdata_d;

  logic        busy;
  logic        irq_edge;
  logic [11:0] rx_next;

  assign busy     = (state_q != S_IDLE);
  assign irq_edge = DEV_IRQ_IN & ~irq_prev_q;

  function automatic bitu_bus_t bitu_write(input logic [7:0] addr, input logic [7:0] data);
    bitu_bus_t op;
    op.addr = addr;
    op.data = data;
    op.wr   = 1'b1;
    op.rd   = 1'b0;
    return op;
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d    = state_q;
    step_d     = step_q;
    bitcnt_d   = bitcnt_q;
    frame_d    = frame_q;
    ctl_base_d = ctl_base_q;
    tx_mode_d  = tx_mode_q;
    parity_d   = parity_q;
    tx_data_d  = tx_data_q;
    rx_data_d  = rx_data_q;
    full_d     = full_q;
    half_d     = half_q;
    done_d     = done_q;
    perr_d     = perr_q;
    ferr_d     = ferr_q;
    edge_sel_d = edge_sel_q;
    irq_en_d   = irq_en_q;
    aux_clk_d  = aux_clk_q;
    bus_d      = '0;
    rdata_d    = BITU_BYTE_ZERO;
    rx_next    = {DEV_RDATA_IN[0], frame_q[11:1]};

    if (CMD_IN.rd) begin
      unique case (CMD_IN.addr)
        BITU_REG_STATUS:   rdata_d = {4'h0, ferr_q, perr_q, done_q, busy};
        BITU_REG_TX_DATA:  rdata_d = tx_data_q;
        BITU_REG_RX_DATA:  rdata_d = rx_data_q;
        BITU_REG_FULL_BIT: rdata_d = full_q;
        BITU_REG_HALF_BIT: rdata_d = half_q;
        BITU_REG_COMMAND:  rdata_d = {4'h0, aux_clk_q, parity_q, ~tx_mode_q & busy, tx_mode_q & busy};
        default:           rdata_d = BITU_BYTE_ZERO;
      endcase
    end

    // Settings only change while idle, so a running frame never sees new timing.
    if (CMD_IN.wr && !busy) begin
      unique case (CMD_IN.addr)
        BITU_REG_TX_DATA:  tx_data_d = CMD_IN.wdata;
        BITU_REG_FULL_BIT: full_d    = CMD_IN.wdata;
        BITU_REG_HALF_BIT: half_d    = CMD_IN.wdata;
        default: ;
      endcase
    end
    if (CMD_IN.wr && CMD_IN.addr == BITU_REG_STATUS && CMD_IN.wdata[BITU_ST_DONE]) begin
      done_d = 1'b0;
    end

    unique case (state_q)
      S_IDLE: begin
        // A start asking for both directions at once is ignored.
        if (CMD_IN.wr && CMD_IN.addr == BITU_REG_COMMAND &&
            (CMD_IN.wdata[BITU_CMD_TX] ^ CMD_IN.wdata[BITU_CMD_RX])) begin
          tx_mode_d  = CMD_IN.wdata[BITU_CMD_TX];
          parity_d   = CMD_IN.wdata[BITU_CMD_PARITY];
          aux_clk_d  = CMD_IN.wdata[BITU_CMD_AUX_CLK];
          ctl_base_d = BITU_M_IRQ_CARRY | (CMD_IN.wdata[BITU_CMD_AUX_CLK] ? BITU_M_CLK_AUX : BITU_M_CLK_MAIN);
          if (CMD_IN.wdata[BITU_CMD_TX]) begin
            ctl_base_d = ctl_base_d | BITU_M_TX_ROUTE;
            frame_d    = {2'b11, CMD_IN.wdata[BITU_CMD_PARITY] ? ^tx_data_q : 1'b1, tx_data_q, 1'b0};
            bitcnt_d   = CMD_IN.wdata[BITU_CMD_PARITY] ? BITU_TX_BITS_PAR : BITU_TX_BITS_NOP;
          end else begin
            frame_d    = '0;
            bitcnt_d   = CMD_IN.wdata[BITU_CMD_PARITY] ? BITU_RX_BITS_PAR : BITU_RX_BITS_NOP;
            edge_sel_d = 1'b1;
          end
          perr_d  = 1'b0;
          ferr_d  = 1'b0;
          step_d  = '0;
          state_d = S_INIT;
        end
      end
      S_INIT: begin
        unique case (step_q)
          3'h0: bus_d = bitu_write(BITU_ADDR_CONTROL, ctl_base_q | (tx_mode_q ? BITU_M_TX_BIT : BITU_BYTE_ZERO));
          3'h1: bus_d = bitu_write(BITU_ADDR_RELOAD, half_q);
          3'h2: bus_d = bitu_write(BITU_ADDR_COUNT, BITU_BYTE_ZERO);
          3'h3: bus_d = bitu_write(BITU_ADDR_RELOAD, full_q);
          default: bus_d = bitu_write(BITU_ADDR_CONTROL, ctl_base_q | BITU_M_RUN |
                                      (tx_mode_q ? BITU_M_TX_BIT : BITU_M_EDGE_ARM));
        endcase
        step_d = step_q + 3'h1;
        if (step_q == BITU_INIT_LAST) begin
          irq_en_d = ~tx_mode_q;
          state_d  = S_WAIT_IRQ;
        end
      end
      S_WAIT_IRQ: begin
        if (irq_edge) begin
          if (!tx_mode_q) begin
            bus_d.addr = BITU_ADDR_CONTROL;
            bus_d.rd   = 1'b1;
            state_d    = S_RD_GAP;
          end else if (bitcnt_q != 4'h0) begin
            // The bit written here appears on the pin at the following carry.
            bus_d = bitu_write(BITU_ADDR_CONTROL, ctl_base_q | BITU_M_RUN |
                               (frame_q[0] ? BITU_M_TX_BIT : BITU_BYTE_ZERO));
            frame_d  = {1'b1, frame_q[11:1]};
            bitcnt_d = bitcnt_q - BITU_ONE;
          end else begin
            bus_d   = bitu_write(BITU_ADDR_CONTROL, BITU_BYTE_ZERO);
            done_d  = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      S_RD_GAP: begin
        state_d = S_RD_TAKE;
      end
      S_RD_TAKE: begin
        frame_d  = rx_next;
        bitcnt_d = bitcnt_q - BITU_ONE;
        state_d  = S_WAIT_IRQ;
        if (bitcnt_q == BITU_ONE) begin
          rx_data_d  = parity_q ? rx_next[9:2] : rx_next[10:3];
          ferr_d     = ~rx_next[11] | (parity_q ? rx_next[1] : rx_next[2]);
          perr_d     = parity_q & (rx_next[10] ^ (^rx_next[9:2]));
          bus_d      = bitu_write(BITU_ADDR_CONTROL, BITU_BYTE_ZERO);
          irq_en_d   = 1'b0;
          edge_sel_d = 1'b0;
          done_d     = 1'b1;
          state_d    = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_q    <= S_IDLE;
      step_q     <= '0;
      bitcnt_q   <= '0;
      frame_q    <= '0;
      ctl_base_q <= BITU_BYTE_ZERO;
      tx_mode_q  <= 1'b0;
      parity_q   <= 1'b0;
      tx_data_q  <= BITU_BYTE_ZERO;
      rx_data_q  <= BITU_BYTE_ZERO;
      full_q     <= BITU_BYTE_ZERO;
      half_q     <= BITU_BYTE_ZERO;
      done_q     <= 1'b0;
      perr_q     <= 1'b0;
      ferr_q     <= 1'b0;
      edge_sel_q <= 1'b0;
      irq_en_q   <= 1'b0;
      irq_prev_q <= 1'b0;
      aux_clk_q  <= 1'b0;
      bus_q      <= '0;
      rdata_q    <= BITU_BYTE_ZERO;
    end else begin
      state_q    <= state_d;
      step_q     <= step_d;
      bitcnt_q   <= bitcnt_d;
      frame_q    <= frame_d;
      ctl_base_q <= ctl_base_d;
      tx_mode_q  <= tx_mode_d;
      parity_q   <= parity_d;
      tx_data_q  <= tx_data_d;
      rx_data_q  <= rx_data_d;
      full_q     <= full_d;
      half_q     <= half_d;
      done_q     <= done_d;
      perr_q     <= perr_d;
      ferr_q     <= ferr_d;
      edge_sel_q <= edge_sel_d;
      irq_en_q   <= irq_en_d;
      irq_prev_q <= DEV_IRQ_IN;
      aux_clk_q  <= aux_clk_d;
      bus_q      <= bus_d;
      rdata_q    <= rdata_d;
    end
  end

  assign CMD_RDATA_OUT              = rdata_q;
  assign DEV_BUS_OUT                = bus_q;
  assign EDGE_FALL_SELECT_OUT       = edge_sel_q;
  assign RECEIVE_PIN_IRQ_ENABLE_OUT = irq_en_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_count_then_full;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (bus_q.wr && bus_q.addr == BITU_ADDR_COUNT) |=> (bus_q.wr && bus_q.addr == BITU_ADDR_RELOAD && bus_q.data == full_q);
  endproperty
  a_count_then_full: assert property (p_count_then_full) else $error("Preload not set to full bit after count load.");

  property p_half_before_count;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (bus_q.wr && bus_q.addr == BITU_ADDR_COUNT) |-> ($past(bus_q.addr) == BITU_ADDR_RELOAD && $past(bus_q.data) == half_q);
  endproperty
  a_half_before_count: assert property (p_half_before_count) else $error("Count loaded without half bit preload.");

  property p_mark_before_run;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (bus_q.wr && bus_q.addr == BITU_ADDR_CONTROL && tx_mode_q && $past(state_q) == S_INIT &&
       (bus_q.data & BITU_M_RUN) != BITU_BYTE_ZERO) |-> (bus_q.data & BITU_M_TX_BIT) != BITU_BYTE_ZERO;
  endproperty
  a_mark_before_run: assert property (p_mark_before_run) else $error("Counter enabled without mark on transmit bit.");

  property p_edge_before_arm;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (bus_q.wr && bus_q.addr == BITU_ADDR_CONTROL && (bus_q.data & BITU_M_EDGE_ARM) != BITU_BYTE_ZERO) |->
        edge_sel_q && !tx_mode_q;
  endproperty
  a_edge_before_arm: assert property (p_edge_before_arm) else $error("Edge armed without falling edge select.");

  property p_rx_irq_enabled;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q == S_WAIT_IRQ && !tx_mode_q) |-> irq_en_q;
  endproperty
  a_rx_irq_enabled: assert property (p_rx_irq_enabled) else $error("Receiving without pin interrupt enable.");

  property p_one_direction;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      // Timing values written to the preload share bit positions with the control flags.
      (bus_q.wr && bus_q.addr == BITU_ADDR_CONTROL) |->
        ((bus_q.data & BITU_M_TX_ROUTE) == BITU_BYTE_ZERO) || ((bus_q.data & BITU_M_EDGE_ARM) == BITU_BYTE_ZERO);
  endproperty
  a_one_direction: assert property (p_one_direction) else $error("Transmit route and edge arm together.");

  property p_off_at_done;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      $rose(done_q) |-> bus_q.wr && bus_q.addr == BITU_ADDR_CONTROL && bus_q.data == BITU_BYTE_ZERO && !irq_en_q;
  endproperty
  a_off_at_done: assert property (p_off_at_done) else $error("Character finished without switching timer off.");

  property p_single_access;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (bus_q.rd |-> !bus_q.wr) and (bus_q.rd |=> !bus_q.rd && !bus_q.wr);
  endproperty
  a_single_access: assert property (p_single_access) else $error("Overlapping device accesses.");

  property p_errors_at_end;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      ($rose(ferr_q) || $rose(perr_q)) |-> $past(state_q) == S_RD_TAKE && $rose(done_q);
  endproperty
  a_errors_at_end: assert property (p_errors_at_end) else $error("Error flag set outside frame end.");

  property p_read_control;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      bus_q.rd |-> bus_q.addr == BITU_ADDR_CONTROL && !tx_mode_q;
  endproperty
  a_read_control: assert property (p_read_control) else $error("Device read outside receive sampling.");

  property p_run_setup;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (bus_q.wr && bus_q.addr == BITU_ADDR_CONTROL && (bus_q.data & BITU_M_RUN) != BITU_BYTE_ZERO) |->
        (bus_q.data & BITU_M_IRQ_CARRY) != BITU_BYTE_ZERO &&
        ((bus_q.data & BITU_M_TX_ROUTE) != BITU_BYTE_ZERO) == tx_mode_q;
  endproperty
  a_run_setup: assert property (p_run_setup) else $error("Running counter with wrong source or route.");

  property p_clock_choice;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (bus_q.wr && bus_q.addr == BITU_ADDR_CONTROL && bus_q.data != BITU_BYTE_ZERO) |->
        (bus_q.data & (BITU_M_CLK_MAIN | BITU_M_CLK_AUX)) == (aux_clk_q ? BITU_M_CLK_AUX : BITU_M_CLK_MAIN);
  endproperty
  a_clock_choice: assert property (p_clock_choice) else $error("Counter clock select differs from command.");

  c_tx_done: cover property (@(posedge CLOCK_IN) disable iff (RST_IN) $rose(done_q) && tx_mode_q);
  c_rx_done: cover property (@(posedge CLOCK_IN) disable iff (RST_IN) $rose(done_q) && !tx_mode_q);
  c_rx_ferr: cover property (@(posedge CLOCK_IN) disable iff (RST_IN) $rose(ferr_q));
  c_rx_perr: cover property (@(posedge CLOCK_IN) disable iff (RST_IN) $rose(perr_q));
  c_aux_done: cover property (@(posedge CLOCK_IN) disable iff (RST_IN) $rose(done_q) && aux_clk_q);

endmodule

// ==== bitu_dev_model.sv ====
// Behavioural model of the bit interval timer device on the controller's far side.
`timescale 1ns/100ps
module bitu_dev_model
  import bitu_pkg::*;
#(
  parameter int   AUX_DIV  = 4,
  parameter logic PORT_BIT = 1'b0
)(
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  input  wire bitu_bus_t bus_in,
  output logic [7:0]     rdata_out,
  output logic           irq_out,
  input  wire logic      rx_pin_in,
  input  wire logic      fall_sel_in,
  input  wire logic      pin_irq_en_in,
  output logic           tx_pin_out
);
  // ************************************************
  // Registers, counter and pins
  // ************************************************
  logic [7:0] ctl_q;
  logic [7:0] pld_q;
  logic [7:0] cnt_q;
  logic       edge_q;
  logic       rx_q;
  logic       tx_q;
  logic       tick;
  logic       go;
  logic       carry;
  logic       pin_evt;
  int         aux_q;

  assign pin_evt    = fall_sel_in ? (rx_q & ~rx_pin_in) : (~rx_q & rx_pin_in);
  assign go         = tick & ctl_q[3] & (~ctl_q[2] | edge_q);
  assign carry      = go & (cnt_q == 8'hFF);
  assign tx_pin_out = ctl_q[4] ? tx_q : PORT_BIT;

  always_comb begin
    case (ctl_q[7:6])
      2'h0: tick = pin_evt;
      2'h1: tick = 1'b1;
      2'h2: tick = (aux_q == AUX_DIV - 1);
      default: tick = rx_pin_in;
    endcase
  end

  // Preload and count keep their contents over reset, as the real part does.
  always_ff @(posedge clk_in) begin
    rx_q <= rx_pin_in;
    if (bus_in.wr && bus_in.addr == BITU_ADDR_COUNT) cnt_q <= pld_q;
    else if (go) cnt_q <= carry ? pld_q : cnt_q + 8'h01;
    if (bus_in.wr && bus_in.addr == BITU_ADDR_RELOAD) pld_q <= bus_in.data;
    if (rst_in) begin
      ctl_q     <= 8'h00;
      edge_q    <= 1'b0;
      irq_out   <= 1'b0;
      rdata_out <= 8'h00;
      aux_q     <= 0;
      tx_q      <= 1'b0;
    end else begin
      aux_q   <= (aux_q >= AUX_DIV - 1) ? 0 : aux_q + 1;
      if (carry) tx_q <= ctl_q[1];
      if (bus_in.wr && bus_in.addr == BITU_ADDR_CONTROL) ctl_q <= bus_in.data;
      edge_q  <= ctl_q[2] & (edge_q | (rx_q & ~rx_pin_in));
      irq_out <= ctl_q[5] ? carry : (pin_irq_en_in & pin_evt);
      // Read data toggle when not read, so a late sample never sees stale data.
      if (!bus_in.rd) rdata_out <= ~rdata_out;
      else if (bus_in.addr == BITU_ADDR_CONTROL) rdata_out <= {ctl_q[7:1], rx_pin_in};
      else if (bus_in.addr == BITU_ADDR_RELOAD) rdata_out <= pld_q;
      else if (bus_in.addr == BITU_ADDR_COUNT) rdata_out <= cnt_q;
      else rdata_out <= ~rdata_out;
    end
  end
endmodule

// ==== bitu_ctrl_test.sv ====
// Self-checking testbench for the bit interval timer serial controller.
`timescale 1ns/100ps
module bitu_ctrl_test;
  import bitu_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } bitu_row_t;
  localparam int BIT_CYC = 10;
  localparam int AUX_DIV = 4;
  localparam bitu_row_t ROWS [12] = '{
    '{1'b0, 4'h1, 8'h00, 8'h00}, '{1'b0, 4'h3, 8'h00, 8'h00}, '{1'b0, 4'h0, 8'h00, 8'h00},
    '{1'b1, 4'h2, 8'h5A, 8'h00}, '{1'b0, 4'h2, 8'h00, 8'h5A}, '{1'b1, 4'h4, 8'hF6, 8'h00},
    '{1'b0, 4'h4, 8'h00, 8'hF6}, '{1'b1, 4'h5, 8'hFB, 8'h00}, '{1'b0, 4'h5, 8'h00, 8'hFB},
    '{1'b1, 4'h3, 8'h77, 8'h00}, '{1'b0, 4'hF, 8'h00, 8'h00}, '{1'b0, 4'h3, 8'h00, 8'h00}};
  localparam logic [7:0] RX_DAT [3] = '{8'h3C, 8'h81, 8'h55};
  localparam logic [7:0] RX_CMD [3] = '{8'h06, 8'h0E, 8'h02};
  localparam logic [7:0] RX_ST  [3] = '{8'h02, 8'h06, 8'h0A};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  bitu_cmd_t  cmd = '0;
  bitu_bus_t  dev_bus;
  logic [7:0] rdata;
  logic [7:0] dev_rdata;
  logic [7:0] got;
  logic       dev_irq;
  logic       fall_sel;
  logic       pin_irq_en;
  logic       tx_pin;
  logic       rx_line = 1'b1;
  logic       cap_en = 1'b0;
  logic       txq [$];
  logic [12:0] exp_bits;
  int         fails = 0;
  int         comparisons = 0;

  always #2 clk = ~clk;
  always @(negedge clk) if (cap_en && dev_irq) txq.push_back(tx_pin);

  bitu_ctrl bitu_ctrl_inst (.CLOCK_IN(clk), .RST_IN(rst), .CMD_IN(cmd), .CMD_RDATA_OUT(rdata),
    .DEV_BUS_OUT(dev_bus), .DEV_RDATA_IN(dev_rdata), .DEV_IRQ_IN(dev_irq),
    .EDGE_FALL_SELECT_OUT(fall_sel), .RECEIVE_PIN_IRQ_ENABLE_OUT(pin_irq_en));
  bitu_dev_model #(.AUX_DIV(AUX_DIV), .PORT_BIT(1'b0)) bitu_dev_model_inst (.clk_in(clk),
    .rst_in(rst), .bus_in(dev_bus), .rdata_out(dev_rdata), .irq_out(dev_irq), .rx_pin_in(rx_line),
    .fall_sel_in(fall_sel), .pin_irq_en_in(pin_irq_en), .tx_pin_out(tx_pin));

  // ************************************************
  // Bus tasks, checks and scenarios
  // ************************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cmd <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    cmd <= '0;
  endtask
  task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    cmd <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    cmd <= '0;
    #1 d = rdata;
  endtask
  task automatic wait_done();
    int n;
    logic [7:0] v;
    n = 0;
    v = 8'h00;
    while (v[BITU_ST_DONE] !== 1'b1 && n < 4000) begin
      sw_rd(BITU_REG_STATUS, v);
      n++;
    end
    if (v[BITU_ST_DONE] !== 1'b1) begin
      fails++;
      $display("BAD %0t frame never finished", $time);
    end
  endtask
  task automatic rx_frame(input logic [7:0] d, input logic [7:0] c, input logic flip, input logic stp);
    int bper;
    int nb;
    logic [10:0] fr;
    bper = c[BITU_CMD_AUX_CLK] ? BIT_CYC * AUX_DIV : BIT_CYC;
    nb = c[BITU_CMD_PARITY] ? 11 : 10;
    fr = c[BITU_CMD_PARITY] ? {stp, (^d) ^ flip, d, 1'b0} : {1'b1, stp, d, 1'b0};
    sw_wr(BITU_REG_COMMAND, c);
    repeat (8) @(posedge clk);
    #1 chk({6'h00, fall_sel, pin_irq_en}, 8'h03);
    chk(bitu_dev_model_inst.ctl_q, c[3] ? 8'hAC : 8'h6C);
    @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= fr[i];
      repeat (bper) @(posedge clk);
    end
    rx_line <= 1'b1;
    wait_done();
  endtask
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) sw_wr(ROWS[i].a, ROWS[i].d);
      else begin
        sw_rd(ROWS[i].a, got);
        chk(got, ROWS[i].e);
      end
    end
    sw_wr(BITU_REG_COMMAND, 8'h03);
    sw_rd(BITU_REG_COMMAND, got);
    chk(got | bitu_dev_model_inst.ctl_q, 8'h00);
    // Transmit with parity; the busy-time writes must all be dropped.
    sw_wr(BITU_REG_TX_DATA, 8'hA5);
    cap_en = 1'b1;
    sw_wr(BITU_REG_COMMAND, 8'h05);
    sw_wr(BITU_REG_TX_DATA, 8'h00);
    sw_wr(BITU_REG_COMMAND, 8'h02);
    sw_rd(BITU_REG_COMMAND, got);
    chk(got, 8'h05);
    chk(bitu_dev_model_inst.ctl_q & 8'hFD, 8'h78);
    wait_done();
    cap_en = 1'b0;
    exp_bits = {1'b1, 1'b1, ^8'hA5, 8'hA5, 1'b0, 1'b1};
    chk(8'(txq.size()), 8'h0D);
    foreach (txq[i]) chk({7'h00, txq[i]}, {7'h00, exp_bits[i]});
    chk({7'h00, tx_pin}, 8'h00);
    sw_rd(BITU_REG_TX_DATA, got);
    chk(got, 8'hA5);
    sw_rd(BITU_REG_STATUS, got);
    chk(got, 8'h02);
    // Transmit again without parity on the auxiliary clock: one bit interval fewer.
    sw_wr(BITU_REG_STATUS, 8'h02);
    txq.delete();
    cap_en = 1'b1;
    sw_wr(BITU_REG_COMMAND, 8'h09);
    wait_done();
    cap_en = 1'b0;
    exp_bits = {1'b0, 1'b1, 1'b1, 8'hA5, 1'b0, 1'b1};
    chk(8'(txq.size()), 8'h0C);
    foreach (txq[i]) chk({7'h00, txq[i]}, {7'h00, exp_bits[i]});
    // Receive: clean frame, bad parity on the aux clock, space stop bit.
    for (int c = 0; c < 3; c++) begin
      sw_wr(BITU_REG_STATUS, 8'h02);
      rx_frame(RX_DAT[c], RX_CMD[c], c == 1, c != 2);
      sw_rd(BITU_REG_RX_DATA, got);
      chk(got, RX_DAT[c]);
      sw_rd(BITU_REG_STATUS, got);
      chk(got, RX_ST[c]);
      chk({6'h00, fall_sel, pin_irq_en} | bitu_dev_model_inst.ctl_q, 8'h00);
    end
    sw_wr(BITU_REG_STATUS, 8'h02);
    sw_rd(BITU_REG_STATUS, got);
    chk(got, 8'h08);
    conclude();
  end
endmodule
